// file: common/icmc_consts.svh
// Constants for the input capture mode control block.
`ifndef ICMC_CONSTS_SVH
`define ICMC_CONSTS_SVH
`define ICMC_OFF_CAP_CTRL 12'h000
`define ICMC_OFF_GATE_CTRL 12'h004
`define ICMC_OFF_IRQ_STAT 12'h008
`define ICMC_OFF_IRQ_EN 12'h00c
`define ICMC_OFF_IRQ_CLR 12'h010
`define ICMC_OFF_STATE 12'h014
`define ICMC_MODE_LSB 0
`define ICMC_MODE_MSB 2
`define ICMC_OVF_BIT 4
`define ICMC_BNE_BIT 3
`define ICMC_CPI_LSB 5
`define ICMC_CPI_MSB 6
`define ICMC_CTRL_WMASK 16'h3c67
`define ICMC_CAP_DIS_LSB 8
`define ICMC_CAP_DIS_MSB 11
`define ICMC_CMP_DIS_LSB 0
`define ICMC_CMP_DIS_MSB 3
`define ICMC_GATE_WMASK 16'h0f0f
`define ICMC_RESET_16 16'h0000
`define ICMC_EV_WAKE 0
`define ICMC_EV_CAPTURE 1
`define ICMC_EV_OVERFLOW 2
`define ICMC_EV_COUNT 3
`define ICMC_FIFO_DEPTH 4
`endif

// file: common/icmc_pkg.sv
// Types shared by the input capture mode control block.
package icmc_pkg;
    typedef enum logic [2:0] {
        ICMC_MODE_OFF = 3'h0,
        ICMC_MODE_EVERY = 3'h1,
        ICMC_MODE_FALL = 3'h2,
        ICMC_MODE_RISE = 3'h3,
        ICMC_MODE_RISE4 = 3'h4,
        ICMC_MODE_RISE16 = 3'h5,
        ICMC_MODE_UNUSED = 3'h6,
        ICMC_MODE_WAKEPIN = 3'h7
    } icmc_mode_e;
    typedef enum logic [1:0] {
        ICMC_ST_OFF = 2'h0,
        ICMC_ST_CAPTURE = 2'h1,
        ICMC_ST_WAKE = 2'h2,
        ICMC_ST_IDLE = 2'h3
    } icmc_state_e;
    typedef logic [15:0] icmc_word_t;
endpackage

// file: rtl/icmc_apb.sv
// APB slave decode for the mode control registers, answer after one wait state.
`timescale 1ns/10ps
module icmc_apb (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    output logic wr_o,
    output logic rd_o,
    output logic pready_o
);
    // Ready is registered so every access takes exactly one wait state.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pready_o <= 1'b0;
        end else if (ce_i) begin
            pready_o <= psel_i & penable_i & ~pready_o;
        end
    end
    assign wr_o = ce_i & psel_i & penable_i & pready_o & pwrite_i;
    assign rd_o = ce_i & psel_i & penable_i & ~pready_o & ~pwrite_i;
endmodule

// file: rtl/icmc_edge.sv
// Edge detector for the capture pin.
`timescale 1ns/10ps
module icmc_edge (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic pin_i,
    output logic rise_o,
    output logic fall_o
);
    logic last_r;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            last_r <= 1'b0;
        end else if (ce_i) begin
            last_r <= pin_i;
        end
    end
    assign rise_o = ce_i & pin_i & ~last_r;
    assign fall_o = ce_i & ~pin_i & last_r;
endmodule

// file: rtl/icmc_top.sv
// Mode control and enable slice of a four unit input capture block.
//
// Contract
// - Mode 111 only flags rising edges, only while CPU sleeps or idles.
// - Mode 111 ignores other control fields and all falling edges.
// - Mode 110 is unused and behaves as disabled with no captures.
// - Mode 000 switches the capture unit fully off.
// - Gate bits 11..8 disable capture units one to four when set.
// - Gate bits 3..0 disable compare units one to four when set.
`timescale 1ns/10ps
`include "icmc_consts.svh"
module icmc_top #(
    parameter int UNITS = 4
) (
    input wire logic CLOCK_I,
    input wire logic RESET_I,
    input wire logic CE_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic CAP_PIN_I,
    input wire logic CPU_LOWPOWER_I,
    input wire logic CAP_READ_I,
    output logic [UNITS-1:0] CAP_EN_O,
    output logic [UNITS-1:0] CMP_EN_O,
    output logic CAP_STROBE_O,
    output icmc_pkg::icmc_state_e STATE_O,
    output logic IRQ_O
);
    import icmc_pkg::*;

    if (UNITS != 4) begin : g_bad_units
        $error("icmc_top supports exactly four units");
    end

    icmc_word_t ctrl_r;
    icmc_word_t gate_r;
    logic [`ICMC_EV_COUNT-1:0] stat_r;
    logic [`ICMC_EV_COUNT-1:0] en_r;
    logic ovf_r;
    logic [2:0] fill_r;
    logic [3:0] div_r;
    icmc_state_e state_r;
    icmc_state_e state_nxt;
    icmc_mode_e mode;
    logic rise;
    logic fall;
    logic wr;
    logic rd;
    logic unit0_on;
    logic cap_ev;
    logic cap_take;
    logic wake_ev;
    logic ovf_ev;
    logic [`ICMC_EV_COUNT-1:0] ev;
    logic [`ICMC_EV_COUNT-1:0] clr;
    icmc_word_t status_word;
    icmc_word_t rdata;

    icmc_apb u_apb (
        .clk_i(CLOCK_I),
        .rst_i(RESET_I),
        .ce_i(CE_I),
        .psel_i(PSEL_I),
        .penable_i(PENABLE_I),
        .pwrite_i(PWRITE_I),
        .wr_o(wr),
        .rd_o(rd),
        .pready_o(PREADY_O)
    );

    icmc_edge u_edge (
        .clk_i(CLOCK_I),
        .rst_i(RESET_I),
        .ce_i(CE_I),
        .pin_i(CAP_PIN_I),
        .rise_o(rise),
        .fall_o(fall)
    );

    assign mode = icmc_mode_e'(ctrl_r[`ICMC_MODE_MSB:`ICMC_MODE_LSB]);
    assign unit0_on = ~gate_r[`ICMC_CAP_DIS_LSB];

    // Control register with the two hardware flags folded in on reads.
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            ctrl_r <= `ICMC_RESET_16;
        end else if (CE_I && wr && PADDR_I == `ICMC_OFF_CAP_CTRL) begin
            ctrl_r <= PWDATA_I[15:0] & `ICMC_CTRL_WMASK;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            gate_r <= `ICMC_RESET_16;
        end else if (CE_I && wr && PADDR_I == `ICMC_OFF_GATE_CTRL) begin
            gate_r <= PWDATA_I[15:0] & `ICMC_GATE_WMASK;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            en_r <= '0;
        end else if (CE_I && wr && PADDR_I == `ICMC_OFF_IRQ_EN) begin
            en_r <= PWDATA_I[`ICMC_EV_COUNT-1:0];
        end
    end

    // Per-unit enables: a gate bit at one holds its unit disabled.
    genvar gi;
    for (gi = 0; gi < UNITS; gi++) begin : g_unit
        always_ff @(posedge CLOCK_I) begin
            if (RESET_I) begin
                CAP_EN_O[gi] <= 1'b0;
                CMP_EN_O[gi] <= 1'b0;
            end else if (CE_I) begin
                CAP_EN_O[gi] <= ~gate_r[`ICMC_CAP_DIS_LSB+gi];
                CMP_EN_O[gi] <= ~gate_r[`ICMC_CMP_DIS_LSB+gi];
            end
        end
    end

    // Mode decode into the operating state.
    always_comb begin
        state_nxt = ICMC_ST_OFF;
        if (!unit0_on) begin
            state_nxt = ICMC_ST_OFF;
        end else begin
            case (mode)
                ICMC_MODE_OFF: state_nxt = ICMC_ST_OFF;
                ICMC_MODE_UNUSED: state_nxt = ICMC_ST_IDLE;
                ICMC_MODE_WAKEPIN: state_nxt = ICMC_ST_WAKE;
                ICMC_MODE_EVERY,
                ICMC_MODE_FALL,
                ICMC_MODE_RISE,
                ICMC_MODE_RISE4,
                ICMC_MODE_RISE16: state_nxt = ICMC_ST_CAPTURE;
                default: state_nxt = ICMC_ST_OFF;
            endcase
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            state_r <= ICMC_ST_OFF;
        end else if (CE_I) begin
            state_r <= state_nxt;
        end
    end

    // Edge qualification; prescaled modes count rising edges.
    always_comb begin
        cap_ev = 1'b0;
        case (mode)
            ICMC_MODE_EVERY: cap_ev = rise | fall;
            ICMC_MODE_FALL: cap_ev = fall;
            ICMC_MODE_RISE: cap_ev = rise;
            ICMC_MODE_RISE4: cap_ev = rise && div_r[1:0] == 2'h3;
            ICMC_MODE_RISE16: cap_ev = rise && div_r == 4'hf;
            default: cap_ev = 1'b0;
        endcase
    end

    assign cap_take = (state_r == ICMC_ST_CAPTURE) && cap_ev;
    // Only the rising edge and the low-power level count here.
    assign wake_ev = (state_r == ICMC_ST_WAKE) && rise && CPU_LOWPOWER_I;
    assign ovf_ev = cap_take && fill_r == 3'(`ICMC_FIFO_DEPTH);

    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            div_r <= 4'h0;
        end else if (CE_I) begin
            if (state_r != ICMC_ST_CAPTURE) begin
                div_r <= 4'h0;
            end else if (rise) begin
                div_r <= div_r + 4'h1;
            end
        end
    end

    // Buffer occupancy: the data path lives elsewhere, only the count here.
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            fill_r <= 3'h0;
        end else if (CE_I) begin
            if (state_r == ICMC_ST_OFF) begin
                fill_r <= 3'h0;
            end else if (cap_take && !ovf_ev && !(CAP_READ_I && fill_r != 3'h0)) begin
                fill_r <= fill_r + 3'h1;
            end else if (!cap_take && CAP_READ_I && fill_r != 3'h0) begin
                fill_r <= fill_r - 3'h1;
            end
        end
    end

    // Overflow stays set until the buffer drains or the unit is turned off.
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            ovf_r <= 1'b0;
        end else if (CE_I) begin
            if (ovf_ev) begin
                ovf_r <= 1'b1;
            end else if (state_r == ICMC_ST_OFF || fill_r == 3'h0) begin
                ovf_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            CAP_STROBE_O <= 1'b0;
        end else if (CE_I) begin
            CAP_STROBE_O <= cap_take && !ovf_ev;
        end
    end

    assign ev[`ICMC_EV_WAKE] = wake_ev;
    assign ev[`ICMC_EV_CAPTURE] = cap_take;
    assign ev[`ICMC_EV_OVERFLOW] = ovf_ev;
    assign clr = (wr && PADDR_I == `ICMC_OFF_IRQ_CLR) ?
        PWDATA_I[`ICMC_EV_COUNT-1:0] : '0;

    // A new event in the clearing cycle keeps its bit set.
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            stat_r <= '0;
        end else if (CE_I) begin
            stat_r <= (stat_r & ~clr) | ev;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            IRQ_O <= 1'b0;
        end else if (CE_I) begin
            IRQ_O <= |(((stat_r & ~clr) | ev) & en_r);
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            STATE_O <= ICMC_ST_OFF;
        end else if (CE_I) begin
            STATE_O <= state_nxt;
        end
    end

    always_comb begin
        status_word = ctrl_r;
        status_word[`ICMC_OVF_BIT] = ovf_r;
        status_word[`ICMC_BNE_BIT] = fill_r != 3'h0;
    end

    always_comb begin
        rdata = `ICMC_RESET_16;
        case (PADDR_I)
            `ICMC_OFF_CAP_CTRL: rdata = status_word;
            `ICMC_OFF_GATE_CTRL: rdata = gate_r;
            `ICMC_OFF_IRQ_STAT: rdata = 16'(stat_r);
            `ICMC_OFF_IRQ_EN: rdata = 16'(en_r);
            `ICMC_OFF_STATE: rdata = 16'(state_r);
            default: rdata = `ICMC_RESET_16;
        endcase
    end

    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            PRDATA_O <= 32'h0;
            PSLVERR_O <= 1'b0;
        end else if (CE_I) begin
            PRDATA_O <= rd ? {16'h0, rdata} : 32'h0;
            PSLVERR_O <= 1'b0;
        end
    end

    property p_wake_rise;
        @(posedge CLOCK_I) disable iff (RESET_I)
        CE_I && state_r == ICMC_ST_WAKE && rise && CPU_LOWPOWER_I |=>
            stat_r[`ICMC_EV_WAKE];
    endproperty
    chk_wake_rise_sets: assert property (p_wake_rise)
        else $error("wake rise not flagged");

    chk_wake_awake_quiet: assert property (@(posedge CLOCK_I)
        disable iff (RESET_I) !CPU_LOWPOWER_I |-> !wake_ev)
        else $error("wake event while awake");

    chk_wake_no_capture: assert property (@(posedge CLOCK_I)
        disable iff (RESET_I) state_r == ICMC_ST_WAKE |-> !cap_take)
        else $error("capture in wake mode");

    chk_wake_no_fall: assert property (@(posedge CLOCK_I)
        disable iff (RESET_I) fall |-> !wake_ev)
        else $error("falling edge woke");

    sequence s_unused_held;
        mode == ICMC_MODE_UNUSED && unit0_on && CE_I;
    endsequence
    chk_unused_idle: assert property (@(posedge CLOCK_I)
        disable iff (RESET_I) s_unused_held ##1 s_unused_held |->
            state_r == ICMC_ST_IDLE && !cap_take)
        else $error("mode 110 not disabled");

    // A frozen cycle after the mode change postpones the buffer clear.
    chk_off_mode: assert property (@(posedge CLOCK_I)
        disable iff (RESET_I) CE_I && mode == ICMC_MODE_OFF |=>
            state_r == ICMC_ST_OFF ##1 (fill_r == 3'h0 || !$past(CE_I)))
        else $error("mode 000 not off");

    chk_cap_gate: assert property (@(posedge CLOCK_I)
        disable iff (RESET_I) CE_I && gate_r[`ICMC_CAP_DIS_LSB+1] |=>
            !CAP_EN_O[1])
        else $error("capture gate ignored");

    chk_cmp_gate: assert property (@(posedge CLOCK_I)
        disable iff (RESET_I) CE_I && !gate_r[`ICMC_CMP_DIS_LSB+2] |=>
            CMP_EN_O[2])
        else $error("compare gate ignored");

    chk_flag_hw_only: assert property (@(posedge CLOCK_I)
        disable iff (RESET_I) $rose(ovf_r) |-> $past(ovf_ev))
        else $error("overflow set without cause");
endmodule

// file: test/icmc_pin_model.sv
// Behavioural model of the external capture pin source.
`timescale 1ns/10ps
module icmc_pin_model #(
    parameter int LAG = 1
) (
    input wire logic clk_i,
    input wire logic lvl_i,
    output logic pin_o
);
    logic [3:0] dly_r = 4'h0;
    // The pin moves only after a clock edge, so no edge lands in a setup window.
    always_ff @(posedge clk_i) begin
        dly_r <= {dly_r[2:0], lvl_i};
    end
    assign pin_o = dly_r[LAG-1];
endmodule

// file: test/icmc_tb_top.sv
// Self-checking bench for the input capture mode control block.
`timescale 1ns/10ps
`include "icmc_consts.svh"
module icmc_tb_top;
    import icmc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [11:0] padr = 12'h000;
    logic [31:0] pwd = 32'h0;
    logic [31:0] prd;
    logic rdy;
    logic lp = 1'b0;
    logic lvl = 1'b0;
    logic pop = 1'b0;
    logic perr;
    logic pin;
    logic [3:0] cap_en;
    logic [3:0] cmp_en;
    logic strb;
    logic irq;
    icmc_state_e st;
    int error_cnt = 0;
    int comparisons = 0;
    int strobes = 0;
    int n;
    logic [31:0] seed = 32'h0000921b;
    logic [31:0] v;
    logic [2:0] modes [3] = '{3'h0, 3'h6, 3'h3};
    icmc_state_e sts [3] = '{ICMC_ST_OFF, ICMC_ST_IDLE, ICMC_ST_CAPTURE};
    int caps [3] = '{0, 0, 1};

    icmc_top i_icmc_top (.CLOCK_I(clk), .RESET_I(rst), .CE_I(1'b1),
        .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(padr),
        .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(rdy), .PSLVERR_O(perr),
        .CAP_PIN_I(pin), .CPU_LOWPOWER_I(lp), .CAP_READ_I(pop),
        .CAP_EN_O(cap_en), .CMP_EN_O(cmp_en), .CAP_STROBE_O(strb),
        .STATE_O(st), .IRQ_O(irq));
    icmc_pin_model i_icmc_pin_model (.clk_i(clk), .lvl_i(lvl), .pin_o(pin));

    initial begin
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        if (strb === 1'b1) strobes++;
    end

    function automatic logic [31:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [31:0] en_exp(input logic [31:0] g);
        return {24'h0, ~g[11:8], ~g[3:0]};
    endfunction

    task automatic finish_test();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // The master never assumes a latency; it waits on pready under a limit.
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (rdy !== 1'b1 && k < 50);
        if (k >= 50) error_cnt++;
        r = prd;
        chk({31'h0, perr}, 32'h0);
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        chk(r, e);
    endtask
    task automatic pin_to(input logic l);
        lvl <= l;
        repeat (5) @(posedge clk);
    endtask

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rdc(`ICMC_OFF_CAP_CTRL, 32'h0);
        rdc(`ICMC_OFF_GATE_CTRL, 32'h0);
        rdc(12'h018, 32'h0);
        for (int i = 0; i < 8; i++) begin
            v = (i == 0) ? 32'h0f0f : (xorshift() & 32'hffff);
            wr(`ICMC_OFF_GATE_CTRL, v);
            rdc(`ICMC_OFF_GATE_CTRL, v & 32'h0f0f);
            repeat (2) @(posedge clk);
            chk({24'h0, cap_en, cmp_en}, en_exp(v));
        end
        wr(`ICMC_OFF_GATE_CTRL, 32'h0);
        wr(`ICMC_OFF_IRQ_EN, 32'h7);
        rdc(`ICMC_OFF_IRQ_EN, 32'h7);
        // Off and unused codes go first, before any capture fills the buffer.
        for (int i = 0; i < 3; i++) begin
            wr(`ICMC_OFF_CAP_CTRL, {29'h3, modes[i]});
            repeat (3) @(posedge clk);
            chk(st, sts[i]);
            if (i < 2) rdc(`ICMC_OFF_CAP_CTRL, {29'h0, modes[i]});
            n = strobes;
            pin_to(1'b1);
            pin_to(1'b0);
            chk(strobes - n, caps[i]);
        end
        // One capture is held; three more fill the buffer, the next overflows.
        n = strobes;
        repeat (4) begin
            pin_to(1'b1);
            pin_to(1'b0);
        end
        chk(strobes - n, 3);
        rdc(`ICMC_OFF_CAP_CTRL, 32'h1b);
        rdc(`ICMC_OFF_IRQ_STAT, 32'h6);
        pop <= 1'b1;
        repeat (4) @(posedge clk);
        pop <= 1'b0;
        rdc(`ICMC_OFF_CAP_CTRL, 32'h3);
        wr(`ICMC_OFF_IRQ_CLR, 32'h7);
        wr(`ICMC_OFF_CAP_CTRL, 32'h7 | (xorshift() & 32'h3c60));
        repeat (3) @(posedge clk);
        chk(st, ICMC_ST_WAKE);
        rdc(`ICMC_OFF_STATE, 32'h2);
        n = strobes;
        pin_to(1'b1);
        rdc(`ICMC_OFF_IRQ_STAT, 32'h0);
        pin_to(1'b0);
        lp <= 1'b1;
        pin_to(1'b1);
        rdc(`ICMC_OFF_IRQ_STAT, 32'h1);
        chk(irq, 1'b1);
        wr(`ICMC_OFF_IRQ_CLR, 32'h1);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        pin_to(1'b0);
        rdc(`ICMC_OFF_IRQ_STAT, 32'h0);
        chk(strobes - n, 0);
        wr(`ICMC_OFF_IRQ_EN, 32'h0);
        pin_to(1'b1);
        rdc(`ICMC_OFF_IRQ_STAT, 32'h1);
        chk(irq, 1'b0);
        finish_test();
    end
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        finish_test();
    end
endmodule
